//--- design/sps_counter.sv
// Event counter that either wraps or saturates at all ones.
// Assumes inc and clear are single-cycle strobes on the same clock.
`timescale 1ns/100ps
module sps_counter #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clear,    // Restart count at zero
    input  wire logic         inc,      // One event this cycle
    input  wire logic         wrap_en,  // 1 wraps, 0 saturates
    output logic      [W-1:0] count,    // Live count
    output logic              full_hit  // Event seen while at all ones
);
    // ------------------------------------------------------------
    // Count update
    // ------------------------------------------------------------
    logic          at_max;     // Counter holds all ones
    logic [W-1:0]  count_next; // Next value

    assign at_max   = &count;
    assign full_hit = inc & at_max;

    // Clear restarts; an event in the clear cycle is still counted
    always_comb begin
        count_next = count;
        if (clear) begin
            count_next = inc ? W'(1) : '0;
        end else if (inc && (!at_max || wrap_en)) begin
            count_next = count + W'(1);
        end
    end

    // Count register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= count_next;
        end
    end
endmodule

//--- design/sps_pkg.sv
// Shared constants for the strap status and checker counter register bank.
// Assumes an APB slave on a 20 MHz pclk and a pattern checker on that clock.
package sps_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [9:0]  SPS_IDX_STRAP1   = 10'h06e; // Strap status one
    localparam logic [9:0]  SPS_IDX_STRAP2   = 10'h06f; // Strap status two
    localparam logic [9:0]  SPS_IDX_BYTECNT  = 10'h071; // Byte count
    localparam logic [9:0]  SPS_IDX_ERRCTL   = 10'h072; // Error and overflow
    localparam logic [9:0]  SPS_IDX_INTSTS   = 10'h0f0; // Interrupt status
    localparam logic [9:0]  SPS_IDX_INTMASK  = 10'h0f1; // Interrupt mask
    localparam logic [11:0] SPS_ADDR_STRAP1  = {SPS_IDX_STRAP1, 2'b00};
    localparam logic [11:0] SPS_ADDR_STRAP2  = {SPS_IDX_STRAP2, 2'b00};
    localparam logic [11:0] SPS_ADDR_BYTECNT = {SPS_IDX_BYTECNT, 2'b00};
    localparam logic [11:0] SPS_ADDR_ERRCTL  = {SPS_IDX_ERRCTL, 2'b00};
    localparam logic [11:0] SPS_ADDR_INTSTS  = {SPS_IDX_INTSTS, 2'b00};
    localparam logic [11:0] SPS_ADDR_INTMASK = {SPS_IDX_INTMASK, 2'b00};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SPS_S1_MIRROR   = 15;
    localparam int SPS_S1_DSHIFT   = 14;
    localparam int SPS_S1_CLKOFF   = 13;
    localparam int SPS_S1_RGMIIOFF = 12;
    localparam int SPS_S1_SGMIION  = 11;
    localparam int SPS_S1_XOVROFF  = 10;
    localparam int SPS_S1_FORCEX   = 9;
    localparam int SPS_S1_HALFDUP  = 8;
    localparam int SPS_S1_ANEGOFF  = 7;
    localparam int SPS_S1_ANEGSEL  = 5;
    localparam int SPS_S1_ADDR_LO  = 0;
    localparam int SPS_S2_FLD      = 10;
    localparam int SPS_S2_TXSK_LO  = 4;
    localparam int SPS_S2_RXSK_LO  = 0;
    localparam int SPS_C2_PKTOVF   = 10;
    localparam int SPS_C2_BYTEOVF  = 9;
    localparam int SPS_C2_ERR_LO   = 0;
    localparam int SPS_C2_LOCK     = 0;
    localparam int SPS_C2_LOCKCLR  = 1;

    // Interrupt status and mask bit positions
    localparam int SPS_INT_BYTEOVF = 0;
    localparam int SPS_INT_PKTOVF  = 1;
    localparam int SPS_INT_ERRBYTE = 2;
    localparam int SPS_INT_STRAPS  = 3;
    localparam int SPS_INT_W       = 4;

    // ------------------------------------------------------------
    // Widths, reset values and timing
    // ------------------------------------------------------------
    localparam int SPS_STRAP_W = 21;               // All strap pins
    localparam int SPS_BYTE_W  = 16;
    localparam int SPS_ERR_W   = 8;
    localparam logic [15:0] SPS_BYTE_RST = 16'h0000;
    localparam logic [7:0]  SPS_ERR_RST  = 8'h00;
    localparam logic [1:0]  SPS_SETTLE   = 2'h2;   // Edges after sync
    localparam logic [31:0] SPS_ZERO32   = 32'h0000_0000;

    // APB answer states, one-hot
    typedef enum logic [1:0] {
        SPS_ST_IDLE   = 2'b01,
        SPS_ST_ANSWER = 2'b10
    } sps_apb_state_t;

endpackage

//--- design/sps_regbank.sv
// Strap status and pattern checker counter registers behind an APB port.
// Assumes straps are pins held steady through reset, and that the checker
// strobes and the count-mode level come from logic on pclk.
`timescale 1ns/100ps
module sps_regbank (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Strap pins, asynchronous levels
    input  wire logic        mirror_strap,
    input  wire logic        downshift_strap,
    input  wire logic        clock_output_off_strap,
    input  wire logic        reduced_gmii_off_strap,
    input  wire logic        serial_gmii_on_strap,
    input  wire logic        auto_crossover_off_strap,
    input  wire logic        forced_crossover_strap,
    input  wire logic        half_duplex_strap,
    input  wire logic        autoneg_off_strap,
    input  wire logic        autoneg_select_strap,
    input  wire logic [3:0]  phy_address_strap,
    input  wire logic        fast_link_detect_strap,
    input  wire logic [2:0]  tx_clock_skew_strap,
    input  wire logic [2:0]  rx_clock_skew_strap,
    // Checker side, same clock
    input  wire logic        counter_saturate_select,
    input  wire logic        checker_byte_valid,
    input  wire logic        checker_byte_error,
    input  wire logic        checker_packet_overflow,
    output logic             checker_clear,
    output logic             irq
);
    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic [sps_pkg::SPS_STRAP_W-1:0] strap_pins;   // Raw pin bundle
    logic [sps_pkg::SPS_STRAP_W-1:0] strap_sync;   // After two flops
    logic [sps_pkg::SPS_STRAP_W-1:0] strap_reg;    // Latched once
    logic                            strap_done_reg; // Capture taken
    logic [1:0]                      settle_reg;   // Edges since release

    assign strap_pins = {mirror_strap, downshift_strap,
                         clock_output_off_strap, reduced_gmii_off_strap,
                         serial_gmii_on_strap, auto_crossover_off_strap,
                         forced_crossover_strap, half_duplex_strap,
                         autoneg_off_strap, autoneg_select_strap,
                         phy_address_strap, fast_link_detect_strap,
                         tx_clock_skew_strap, rx_clock_skew_strap};

    // Pins are outside the clock domain
    sps_sync #(
        .W (sps_pkg::SPS_STRAP_W)
    ) u_strap_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (strap_pins),
        .sync_out (strap_sync)
    );

    // Wait until the synchroniser holds real pin values, then take one
    // snapshot; pins may be reused as outputs later, so never resample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_reg     <= 2'h0;
            strap_done_reg <= 1'b0;
            strap_reg      <= '0;
        end else if (!strap_done_reg) begin
            if (settle_reg == sps_pkg::SPS_SETTLE) begin
                strap_reg      <= strap_sync;
                strap_done_reg <= 1'b1;
            end else begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Strap status words
    // ------------------------------------------------------------
    logic [15:0] strap_one;  // First strap status layout
    logic [15:0] strap_two;  // Second strap status layout

    // Unlisted bits stay zero; no write path reaches these words
    always_comb begin
        strap_one = 16'h0000;
        strap_two = 16'h0000;
        strap_one[sps_pkg::SPS_S1_MIRROR]   = strap_reg[20];
        strap_one[sps_pkg::SPS_S1_DSHIFT]   = strap_reg[19];
        strap_one[sps_pkg::SPS_S1_CLKOFF]   = strap_reg[18];
        strap_one[sps_pkg::SPS_S1_RGMIIOFF] = strap_reg[17];
        strap_one[sps_pkg::SPS_S1_SGMIION]  = strap_reg[16];
        strap_one[sps_pkg::SPS_S1_XOVROFF]  = strap_reg[15];
        strap_one[sps_pkg::SPS_S1_FORCEX]   = strap_reg[14];
        strap_one[sps_pkg::SPS_S1_HALFDUP]  = strap_reg[13];
        strap_one[sps_pkg::SPS_S1_ANEGOFF]  = strap_reg[12];
        strap_one[sps_pkg::SPS_S1_ANEGSEL]  = strap_reg[11];
        strap_one[sps_pkg::SPS_S1_ADDR_LO +: 4] = strap_reg[10:7];
        strap_two[sps_pkg::SPS_S2_FLD]      = strap_reg[6];
        strap_two[sps_pkg::SPS_S2_TXSK_LO +: 3] = strap_reg[5:3];
        strap_two[sps_pkg::SPS_S2_RXSK_LO +: 3] = strap_reg[2:0];
    end

    // ------------------------------------------------------------
    // APB decode and answer
    // ------------------------------------------------------------
    sps_pkg::sps_apb_state_t state_reg;  // Answer sequencer
    logic        setup_phase;    // First cycle of a transfer
    logic        wr_done;        // Write takes effect this edge
    logic [11:0] addr_reg;       // Address seen at setup
    logic        lock_req;       // Lock strobe from a control write
    logic        lockclr_req;    // Lock and clear strobe
    logic        intsts_wr;      // Write-one-to-clear of status
    logic [31:0] rd_word;        // Read mux output
    logic        rd_hit;         // Address is mapped
    // Read sources, declared ahead of the read mux that uses them
    logic [15:0] byte_shown_reg; // Frozen byte count for reads
    logic [15:0] ctl_word;       // Error and overflow register layout
    logic [sps_pkg::SPS_INT_W-1:0] int_sts_reg;   // Sticky events
    logic [sps_pkg::SPS_INT_W-1:0] int_mask_reg;  // 1 lets event through

    assign setup_phase = psel & ~penable;
    assign wr_done     = (state_reg == sps_pkg::SPS_ST_ANSWER) &
                         psel & penable & pwrite & ~pslverr;
    assign lock_req    = wr_done & (addr_reg == sps_pkg::SPS_ADDR_ERRCTL) &
                         pwdata[sps_pkg::SPS_C2_LOCK];
    assign lockclr_req = wr_done & (addr_reg == sps_pkg::SPS_ADDR_ERRCTL) &
                         pwdata[sps_pkg::SPS_C2_LOCKCLR];
    assign intsts_wr   = wr_done & (addr_reg == sps_pkg::SPS_ADDR_INTSTS);

    // One answer cycle: pready is raised by the edge that ends setup, so
    // every transfer completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= sps_pkg::SPS_ST_IDLE;
            pready    <= 1'b0;
        end else begin
            case (state_reg)
                sps_pkg::SPS_ST_IDLE: begin
                    if (setup_phase) begin
                        state_reg <= sps_pkg::SPS_ST_ANSWER;
                        pready    <= 1'b1;
                    end
                end
                sps_pkg::SPS_ST_ANSWER: begin
                    state_reg <= sps_pkg::SPS_ST_IDLE;
                    pready    <= 1'b0;
                end
                default: begin
                    state_reg <= sps_pkg::SPS_ST_IDLE;
                    pready    <= 1'b0;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses answer zero with an error
    always_comb begin
        rd_word = sps_pkg::SPS_ZERO32;
        rd_hit  = 1'b1;
        case (paddr)
            sps_pkg::SPS_ADDR_STRAP1:  rd_word = {16'h0000, strap_one};
            sps_pkg::SPS_ADDR_STRAP2:  rd_word = {16'h0000, strap_two};
            sps_pkg::SPS_ADDR_BYTECNT: rd_word = {16'h0000, byte_shown_reg};
            sps_pkg::SPS_ADDR_ERRCTL:  rd_word = {16'h0000, ctl_word};
            sps_pkg::SPS_ADDR_INTSTS:  rd_word = {28'h0000000, int_sts_reg};
            sps_pkg::SPS_ADDR_INTMASK: rd_word = {28'h0000000, int_mask_reg};
            default:                   rd_hit  = 1'b0;
        endcase
    end

    // Read data and error are registered at setup and stand through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata   <= sps_pkg::SPS_ZERO32;
            pslverr  <= 1'b0;
            addr_reg <= 12'h000;
        end else if (state_reg == sps_pkg::SPS_ST_IDLE && setup_phase) begin
            prdata   <= pwrite ? sps_pkg::SPS_ZERO32 : rd_word;
            pslverr  <= ~rd_hit;
            addr_reg <= paddr;
        end else if (state_reg == sps_pkg::SPS_ST_ANSWER) begin
            prdata  <= sps_pkg::SPS_ZERO32;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checker counters
    // ------------------------------------------------------------
    logic [15:0] byte_live;      // Running byte count
    logic [7:0]  err_live;       // Running error count
    logic        byte_full_hit;  // Byte count passed all ones
    logic [7:0]  err_shown_reg;  // Frozen error count for reads
    logic        byte_ovf_reg;   // Sticky byte overflow
    logic        pkt_ovf_reg;    // Sticky packet overflow

    // Count mode 0 saturates, 1 wraps
    sps_counter #(
        .W (sps_pkg::SPS_BYTE_W)
    ) u_byte_cnt (
        .clk      (pclk),
        .rst_n    (presetn),
        .clear    (lockclr_req),
        .inc      (checker_byte_valid),
        .wrap_en  (counter_saturate_select),
        .count    (byte_live),
        .full_hit (byte_full_hit)
    );

    sps_counter #(
        .W (sps_pkg::SPS_ERR_W)
    ) u_err_cnt (
        .clk      (pclk),
        .rst_n    (presetn),
        .clear    (lockclr_req),
        .inc      (checker_byte_error),
        .wrap_en  (counter_saturate_select),
        .count    (err_live),
        .full_hit ()                                     // No error flag
    );

    // Reads see the snapshot, so a multi-register read stays coherent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_shown_reg <= sps_pkg::SPS_BYTE_RST;
            err_shown_reg  <= sps_pkg::SPS_ERR_RST;
        end else if (lock_req || lockclr_req) begin
            byte_shown_reg <= byte_live;
            err_shown_reg  <= err_live;
        end
    end

    // Overflow flags; an overflow in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_ovf_reg <= 1'b0;
            pkt_ovf_reg  <= 1'b0;
        end else begin
            if (byte_full_hit) begin
                byte_ovf_reg <= 1'b1;
            end else if (lockclr_req) begin
                byte_ovf_reg <= 1'b0;
            end
            if (checker_packet_overflow) begin
                pkt_ovf_reg <= 1'b1;
            end else if (lockclr_req) begin
                pkt_ovf_reg <= 1'b0;
            end
        end
    end

    // Control bits 0 and 1 read back as error count bits; writes to them only act as strobes
    always_comb begin
        ctl_word = 16'h0000;
        ctl_word[sps_pkg::SPS_C2_PKTOVF]  = pkt_ovf_reg;
        ctl_word[sps_pkg::SPS_C2_BYTEOVF] = byte_ovf_reg;
        ctl_word[sps_pkg::SPS_C2_ERR_LO +: 8] = err_shown_reg;
    end

    // Tell the outside packet counter to restart with ours
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            checker_clear <= 1'b0;
        end else begin
            checker_clear <= lockclr_req;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [sps_pkg::SPS_INT_W-1:0] int_evt;       // Events this cycle
    logic                          strap_evt;     // Capture happens this edge

    assign strap_evt = ~strap_done_reg & (settle_reg == sps_pkg::SPS_SETTLE);

    always_comb begin
        int_evt = '0;
        int_evt[sps_pkg::SPS_INT_BYTEOVF] = byte_full_hit;
        int_evt[sps_pkg::SPS_INT_PKTOVF]  = checker_packet_overflow;
        int_evt[sps_pkg::SPS_INT_ERRBYTE] = checker_byte_error;
        int_evt[sps_pkg::SPS_INT_STRAPS]  = strap_evt;
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_sts_reg <= '0;
        end else if (intsts_wr) begin
            int_sts_reg <= (int_sts_reg &
                            ~pwdata[sps_pkg::SPS_INT_W-1:0]) | int_evt;
        end else begin
            int_sts_reg <= int_sts_reg | int_evt;
        end
    end

    // Mask register, all events blocked after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_reg <= '0;
        end else if (wr_done && addr_reg == sps_pkg::SPS_ADDR_INTMASK) begin
            int_mask_reg <= pwdata[sps_pkg::SPS_INT_W-1:0];
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_sts_reg & int_mask_reg);
        end
    end
endmodule

//--- design/sps_sync.sv
// Two flip-flop synchroniser for a bundle of slow pin levels.
// Assumes inputs are quasi-static levels; no multi-bit coherence given.
`timescale 1ns/100ps
module sps_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    logic [W-1:0] meta_reg;   // First stage, read only by second stage

    // Both stages clear on reset; the first never feeds logic directly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

//--- verification/sps_regbank_asserts.sv
// Checker for the strap status and counter register bank.
// Assumes it is bound to sps_regbank and sees only that module's ports.
`timescale 1ns/100ps
module sps_regbank_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        checker_clear
);
    // ----------
    // Helpers
    // ----------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd1; // Strap one read answer
    logic clw; // Lock-and-clear write edge
    assign rd1 = pready && !pwrite && paddr == sps_pkg::SPS_ADDR_STRAP1;
    assign clw = psel && penable && pready && pwrite && pwdata[1]
                 && paddr == sps_pkg::SPS_ADDR_ERRCTL;
    // ----------
    // Properties
    // ----------
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_needs_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    chk_rdata_idle_zero: assert property (
        !pready |-> prdata == 32'h0)
        else $error("prdata nonzero while idle");
    chk_upper_half_zero: assert property (
        pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits nonzero");
    chk_strap_gaps_zero: assert property (
        rd1 |-> !prdata[6] && !prdata[4])
        else $error("strap gap bits nonzero");
    chk_clear_follows: assert property (
        clw |-> ##[1:2] checker_clear)
        else $error("no clear after lock-and-clear");
    chk_clear_one_cycle: assert property (
        checker_clear |=> !checker_clear)
        else $error("clear pulse too long");
    cover property (pslverr);
    cover property (checker_clear);
    cover property (rd1);
endmodule

//--- verification/testbench.sv
// Self-checking bench for the strap status and counter register bank.
// Assumes sps_pkg and the design modules are compiled first.
`timescale 1ns/100ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        irq, clr, err, sat, bv, be, po;
    logic [20:0] st; // Strap pins, packed
    logic [20:0] pat [2] = '{21'h155d6b, 21'h0aa294};
    logic [31:0] ex1 [2] = '{32'h0000aaaa, 32'h00005505};
    logic [31:0] ex2 [2] = '{32'h00000453, 32'h00000024};
    int          miscompares = 0;
    int          num_checks  = 0;
    sps_regbank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mirror_strap(st[20]), .downshift_strap(st[19]),
        .clock_output_off_strap(st[18]), .reduced_gmii_off_strap(st[17]),
        .serial_gmii_on_strap(st[16]), .auto_crossover_off_strap(st[15]),
        .forced_crossover_strap(st[14]), .half_duplex_strap(st[13]),
        .autoneg_off_strap(st[12]), .autoneg_select_strap(st[11]),
        .phy_address_strap(st[10:7]), .fast_link_detect_strap(st[6]),
        .tx_clock_skew_strap(st[5:3]), .rx_clock_skew_strap(st[2:0]),
        .counter_saturate_select(sat), .checker_byte_valid(bv),
        .checker_byte_error(be), .checker_packet_overflow(po),
        .checker_clear(clr), .irq(irq));
    // ----------
    // Tasks
    // ----------
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, logic [31:0] e, string s);
        apb(1'b0, a, 32'h0);
        check(s, e, rd);
    endtask
    // Byte pulses, all of them error bytes when e is set
    task automatic pulse(input int n, input logic e);
        repeat (n) begin
            @(posedge pclk);
            {bv, be} <= {1'b1, e};
        end
        @(posedge pclk);
        {bv, be} <= 2'b00;
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_straps;
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            {presetn, st} <= {1'b0, pat[i]};
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            repeat (4) @(posedge pclk);
            rdchk(sps_pkg::SPS_ADDR_STRAP1, ex1[i], "strap1");
            rdchk(sps_pkg::SPS_ADDR_STRAP2, ex2[i], "strap2");
            apb(1'b1, sps_pkg::SPS_ADDR_STRAP1, 32'hffffffff);
            rdchk(sps_pkg::SPS_ADDR_STRAP1, ex1[i], "strap1 wr");
            rdchk(12'h000, 32'h0, "unmapped");
            check("unmapped err", 32'h1, {31'h0, err});
        end
    endtask
    task automatic t_lock;
        pulse(300, 1'b1);
        apb(1'b1, sps_pkg::SPS_ADDR_ERRCTL, 32'h1);
        rdchk(sps_pkg::SPS_ADDR_BYTECNT, 32'h12c, "bytes");
        rdchk(sps_pkg::SPS_ADDR_ERRCTL, 32'h2c, "errs wrap");
        pulse(10, 1'b0);
        rdchk(sps_pkg::SPS_ADDR_BYTECNT, 32'h12c, "frozen");
        apb(1'b1, sps_pkg::SPS_ADDR_ERRCTL, 32'h2);
        @(posedge pclk);
        check("clear pulse", 32'h1, {31'h0, clr});
        rdchk(sps_pkg::SPS_ADDR_BYTECNT, 32'h136, "lock clr");
        apb(1'b1, sps_pkg::SPS_ADDR_ERRCTL, 32'h1);
        rdchk(sps_pkg::SPS_ADDR_BYTECNT, 32'h0, "cleared");
        rdchk(sps_pkg::SPS_ADDR_ERRCTL, 32'h0, "errs cleared");
    endtask
    task automatic t_sat;
        @(posedge pclk);
        sat <= 1'b0;
        pulse(65537, 1'b1);
        po <= 1'b1;
        @(posedge pclk);
        po <= 1'b0;
        apb(1'b1, sps_pkg::SPS_ADDR_ERRCTL, 32'h1);
        rdchk(sps_pkg::SPS_ADDR_BYTECNT, 32'hffff, "byte sat");
        rdchk(sps_pkg::SPS_ADDR_ERRCTL, 32'h6ff, "ovf");
        rdchk(sps_pkg::SPS_ADDR_INTSTS, 32'hf, "int sts");
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, sps_pkg::SPS_ADDR_INTMASK, 32'h1);
        repeat (3) @(posedge pclk);
        check("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, sps_pkg::SPS_ADDR_INTSTS, 32'hf);
        repeat (3) @(posedge pclk);
        check("irq off", 32'h0, {31'h0, irq});
        apb(1'b1, sps_pkg::SPS_ADDR_ERRCTL, 32'h2);
        rdchk(sps_pkg::SPS_ADDR_ERRCTL, 32'h0ff, "ovf clr");
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, bv, be, po} = 7'h00;
        {paddr, pwdata, sat, st} = {12'h0, 32'h0, 1'b1, pat[0]};
        t_straps();
        t_lock();
        t_sat();
        stop_test();
    end
endmodule
bind sps_regbank sps_regbank_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .checker_clear(checker_clear));
